// ===== hdl/uart_cmd_pkg.sv
package uart_cmd_pkg;
  // ==========================================================
  // Serial link timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned BAUD_BPS = 4_800;
  localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_BPS;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned FRAME_BITS = 10;

  // ==========================================================
  // Frame bytes
  localparam logic [7:0] FRAME_HDR = 8'hA5;
  localparam logic [7:0] ACK_BYTE = 8'h06;
  localparam logic [7:0] NAK_BYTE = 8'h15;
  localparam logic [7:0] CHECKSUM_FAIL_REPLY_BYTE = 8'h51;
  localparam logic [7:0] FRAME_MIN = 8'h03;
  localparam logic [7:0] COUNT_POS = 8'h01;
  localparam logic [7:0] FIRST_CMD_POS = 8'h02;
  localparam logic [7:0] RESP_OVERHEAD = 8'h03;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_READ16 = 8'h52;
  localparam logic [7:0] CMD_READ32 = 8'h44;
  localparam logic [7:0] CMD_WRITE16 = 8'h57;
  localparam logic [7:0] CMD_WRITE32 = 8'h45;
  localparam logic [7:0] CMD_READN = 8'h4E;
  localparam logic [7:0] CMD_WRITEN = 8'h4D;
  localparam logic [7:0] CMD_SELECT = 8'h4C;
  localparam logic [7:0] CMD_DESELECT = 8'h4B;
  localparam logic [7:0] CMD_SETPTR = 8'h41;
  localparam logic [7:0] CMD_SAVE = 8'h53;
  localparam logic [7:0] CMD_PAGE_RD = 8'h42;
  localparam logic [7:0] CMD_PAGE_WR = 8'h50;
  localparam logic [7:0] CMD_ERASE = 8'h4F;

  // ==========================================================
  // Packet lengths and limits
  localparam logic [8:0] LEN_ONE = 9'h001;
  localparam logic [8:0] LEN_TWO = 9'h002;
  localparam logic [8:0] LEN_THREE = 9'h003;
  localparam logic [8:0] LEN_FIVE = 9'h005;
  localparam logic [8:0] LEN_PAGE_WR = 9'h012;
  localparam logic [7:0] XFER16 = 8'h02;
  localparam logic [7:0] XFER32 = 8'h04;
  localparam logic [7:0] PAGE_BYTES = 8'h10;
  localparam logic [8:0] RD_LIMIT = 9'h030;
  localparam logic [8:0] WR_LIMIT = 9'h040;
  localparam logic [7:0] PAGE_FILL = 8'hFF;

  // ==========================================================
  // Registers and straps
  localparam logic [15:0] DEV_ADDR_OFS = 16'h0026;
  localparam logic [7:0] DEV_ADDR_RST = 8'h4C;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_beat_t;
endpackage

// ===== hdl/uart_byte_link.sv
`timescale 1ns/1ps
module uart_byte_link import uart_cmd_pkg::*; #(
  parameter int unsigned BIT_CYC = BIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_pin,
  output logic tx_pin,
  output byte_beat_t rx_beat,
  input wire logic tx_go,
  input wire logic [7:0] tx_data,
  output logic tx_busy
);
  localparam int unsigned CW = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0] FULL = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0] HALF = CW'(BIT_CYC / 2);
  localparam logic [3:0] LAST_DATA = 4'(DATA_BITS - 1);
  localparam logic [3:0] TX_BITS = 4'(FRAME_BITS);

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

  // ==========================================================
  // Receiver: start, eight data bits LSB first, stop
  logic rx_s1_reg;
  logic rx_s2_reg;
  rx_state_t rx_state_reg;
  logic [CW-1:0] rx_cnt_reg;
  logic [3:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
      rx_beat <= '0;
    end else begin
      rx_beat.valid <= 1'b0;
      if (rx_cnt_reg != '0) begin
        rx_cnt_reg <= rx_cnt_reg - 1'b1;
      end
      case (rx_state_reg)
        RX_IDLE: begin
          if (!rx_s2_reg) begin
            rx_cnt_reg <= HALF;
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt_reg == '0) begin
            rx_cnt_reg <= FULL;
            rx_bit_reg <= '0;
            rx_state_reg <= rx_s2_reg ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_cnt_reg == '0) begin
            rx_sh_reg <= {rx_s2_reg, rx_sh_reg[7:1]}; // [RULE_02]
            rx_cnt_reg <= FULL;
            rx_bit_reg <= rx_bit_reg + 1'b1;
            if (rx_bit_reg == LAST_DATA) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_cnt_reg == '0) begin
            rx_beat.valid <= rx_s2_reg; // [RULE_02]
            rx_beat.data <= rx_sh_reg;
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Transmitter: ten bit times per byte, no parity
  logic [CW-1:0] tx_cnt_reg;
  logic [3:0] tx_left_reg;
  logic [9:0] tx_sh_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_pin <= 1'b1;
      tx_busy <= 1'b0;
      tx_cnt_reg <= '0;
      tx_left_reg <= '0;
      tx_sh_reg <= '1;
    end else if (!tx_busy) begin
      if (tx_go) begin
        tx_sh_reg <= {1'b1, tx_data, 1'b0}; // [RULE_02]
        tx_left_reg <= TX_BITS;
        tx_cnt_reg <= '0;
        tx_busy <= 1'b1;
      end
    end else if (tx_cnt_reg != '0) begin
      tx_cnt_reg <= tx_cnt_reg - 1'b1;
    end else if (tx_left_reg == '0) begin
      tx_busy <= 1'b0;
    end else begin
      tx_pin <= tx_sh_reg[0];
      tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
      tx_left_reg <= tx_left_reg - 1'b1;
      tx_cnt_reg <= FULL; // [RULE_01]
    end
  end
endmodule

// ===== hdl/framed_uart_command_port.sv
// Contract
// RULE_01 - Link runs at 4.8 kbps by default on both ends.
// RULE_02 - Each byte is start bit, eight data bits, stop bit, no parity.
// RULE_03 - Selected in multi-device mode, direction output stays high until de-select.
// RULE_04 - Host selects one device, sends frames, then de-selects it.
// RULE_05 - Address resets to 0x4C; in multi mode straps replace bits 1:0.
// RULE_06 - Bus address is a writable register at location 0x0026.
// RULE_07 - Read 16 is 0x52, read 32 is 0x44; answered with ack, data, checksum.
// RULE_08 - Write 16 is 0x57 (3 bytes), write 32 is 0x45 (5 bytes); ack only.
// RULE_09 - N-byte read 0x4E takes a count; N-byte write 0x4D takes count and data.
// RULE_10 - Storage commands 0x53, 0x42, 0x50 and 0x4F are accepted.
// RULE_11 - 16/32-bit reads return bytes at the pointer, most significant first.
// RULE_12 - 32-bit write stores four bytes at the pointer and acknowledges.
// RULE_13 - Read bytes per frame never exceed 48.
// RULE_14 - N-byte read returns bytes least significant first, then checksum.
// RULE_15 - Write bytes per frame never exceed 64.
// RULE_16 - Select 0x4C compares address; on match in multi mode drive direction high.
// RULE_17 - De-select 0x4B on address match drops direction output and acknowledges.
// RULE_18 - Set pointer 0x41 loads two bytes; acknowledged only when in range.
// RULE_19 - No command executes until count and checksum of the frame check.
// RULE_20 - Checksum is byte sum modulo 256; mismatch replies 0x51, executes nothing.
// RULE_21 - Data replies are framed with 0x06 in place of header, plus checksum.
// RULE_22 - Host frames open with 0xA5, then total count, packets, checksum.
// RULE_23 - Bad frames leave no side effects; receiver hunts for next header.
`timescale 1ns/1ps
module framed_uart_command_port import uart_cmd_pkg::*; #(
  parameter int unsigned BIT_CYCLES_P = BIT_CYCLES,
  parameter int unsigned REG_BYTES = 256
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic UART_RX,
  output logic UART_TX,
  input wire logic MODE_DIR_IN,
  output logic MODE_DIR_OUT,
  output logic MODE_DIR_OE_N,
  input wire logic ADDRESS_STRAP_BIT0,
  input wire logic ADDRESS_STRAP_BIT1
);
  localparam int unsigned AW = $clog2(REG_BYTES);
  localparam logic [16:0] REG_SPAN = 17'(REG_BYTES);

  typedef enum {ST_HUNT, ST_COUNT, ST_BODY, ST_EXEC, ST_RD, ST_WR, ST_REPLY,
                ST_SEND} state_t;

  // ==========================================================
  // Serial link
  byte_beat_t rx_beat;
  logic tx_busy;
  logic tx_go_reg;
  logic [7:0] tx_byte_reg;

  uart_byte_link #(
    .BIT_CYC(BIT_CYCLES_P)
  ) link_u (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .rx_pin(UART_RX),
    .tx_pin(UART_TX),
    .rx_beat(rx_beat),
    .tx_go(tx_go_reg),
    .tx_data(tx_byte_reg),
    .tx_busy(tx_busy)
  );

  // ==========================================================
  // Strap capture after reset release
  logic mode_s1_reg;
  logic mode_s2_reg;
  logic [1:0] strap_s1_reg;
  logic [1:0] strap_s2_reg;
  logic [1:0] strap_cnt_reg;
  logic strap_done_reg;
  logic strap_take;
  logic multi;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mode_s1_reg <= 1'b1;
      mode_s2_reg <= 1'b1;
      strap_s1_reg <= '0;
      strap_s2_reg <= '0;
    end else begin
      mode_s1_reg <= MODE_DIR_IN;
      mode_s2_reg <= mode_s1_reg;
      strap_s1_reg <= {ADDRESS_STRAP_BIT1, ADDRESS_STRAP_BIT0};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  assign strap_take = !strap_done_reg && (strap_cnt_reg == STRAP_SETTLE);
  assign multi = !MODE_DIR_OE_N;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      strap_cnt_reg <= '0;
      strap_done_reg <= 1'b0;
      MODE_DIR_OE_N <= 1'b1;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 1'b1;
      if (strap_take) begin
        strap_done_reg <= 1'b1;
        MODE_DIR_OE_N <= mode_s2_reg;
      end
    end
  end

  // ==========================================================
  // Frame and response storage
  logic [7:0] fbuf [0:255];
  logic [7:0] rbuf [0:47];
  logic [7:0] regs [0:REG_BYTES-1];
  logic [7:0] dev_addr_reg;

  state_t state_reg;
  logic [7:0] fpos_reg;
  logic [7:0] fcnt_reg;
  logic [7:0] sum_reg;
  logic [7:0] idx_reg;
  logic [15:0] ptr_reg;
  logic [7:0] nbytes_reg;
  logic [7:0] k_reg;
  logic msb_reg;
  logic fill_reg;
  logic [7:0] rlen_reg;
  logic [7:0] rd_total_reg;
  logic [7:0] wr_total_reg;
  logic [7:0] head_reg;
  logic single_reg;
  logic [7:0] tlen_reg;
  logic [7:0] tpos_reg;
  logic [7:0] tsum_reg;

  always_ff @(posedge CORE_CLK) begin
    if (state_reg == ST_BODY && rx_beat.valid) begin
      fbuf[fpos_reg] <= rx_beat.data;
    end
  end

  // ==========================================================
  // Command decode helpers
  function automatic logic [8:0] pkt_len(input logic [7:0] c, input logic [7:0] p);
    case (c)
      CMD_READ16, CMD_READ32: pkt_len = LEN_ONE;
      CMD_WRITE16, CMD_SETPTR: pkt_len = LEN_THREE;
      CMD_WRITE32: pkt_len = LEN_FIVE;
      CMD_WRITEN: pkt_len = LEN_TWO + {1'b0, p};
      CMD_PAGE_WR: pkt_len = LEN_PAGE_WR;
      CMD_READN, CMD_SELECT, CMD_DESELECT, CMD_SAVE, CMD_PAGE_RD,
      CMD_ERASE: pkt_len = LEN_TWO;
      default: pkt_len = LEN_ONE;
    endcase
  endfunction

  function automatic logic [7:0] xfer_len(input logic [7:0] c, input logic [7:0] p);
    case (c)
      CMD_READ16, CMD_WRITE16: xfer_len = XFER16;
      CMD_READ32, CMD_WRITE32: xfer_len = XFER32;
      CMD_READN, CMD_WRITEN: xfer_len = p;
      CMD_PAGE_RD: xfer_len = PAGE_BYTES;
      default: xfer_len = '0;
    endcase
  endfunction

  logic [7:0] cmd;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [8:0] plen;
  logic [7:0] nb;
  logic [7:0] last;
  logic overrun;
  logic span_over;
  logic rd_over;
  logic wr_over;
  logic addr_hit;
  logic quiet;
  logic [7:0] off;
  logic [15:0] acc_addr;
  logic [7:0] rd_byte;
  logic wr_en;
  logic [7:0] tx_pick;

  assign cmd = fbuf[idx_reg];
  assign p1 = fbuf[idx_reg + 8'h01];
  assign p2 = fbuf[idx_reg + 8'h02];
  assign plen = pkt_len(cmd, p1);
  assign nb = xfer_len(cmd, p1);
  assign last = fcnt_reg - 8'h01;
  assign overrun = ({1'b0, idx_reg} + plen) > {1'b0, last};
  assign span_over = ({1'b0, ptr_reg} + {9'h000, nb}) > REG_SPAN;
  assign rd_over = ({1'b0, rd_total_reg} + {1'b0, nb}) > RD_LIMIT // [RULE_13]
                   || (cmd != CMD_PAGE_RD && span_over);
  assign wr_over = ({1'b0, wr_total_reg} + {1'b0, nb}) > WR_LIMIT // [RULE_15]
                   || span_over;
  assign addr_hit = (p1 == dev_addr_reg);
  // Unselected device on a shared bus ignores all but a select
  assign quiet = multi && !MODE_DIR_OUT // [RULE_04]
                 && (fcnt_reg == FRAME_MIN || fbuf[FIRST_CMD_POS] != CMD_SELECT);

  // Byte order: MSB first for fixed widths, LSB first for N-byte
  assign off = msb_reg ? (nbytes_reg - 8'h01 - k_reg) : k_reg; // [RULE_11] [RULE_14]
  assign acc_addr = ptr_reg + {8'h00, off};
  assign rd_byte = fill_reg ? PAGE_FILL
                 : (acc_addr == DEV_ADDR_OFS) ? dev_addr_reg : regs[acc_addr[AW-1:0]];
  assign wr_en = (state_reg == ST_WR) && (k_reg != nbytes_reg);

  assign tx_pick = (tpos_reg == 8'h00) ? head_reg // [RULE_21]
                 : (tpos_reg == COUNT_POS) ? tlen_reg
                 : (tpos_reg == tlen_reg - 8'h01) ? tsum_reg
                 : rbuf[6'(tpos_reg - FIRST_CMD_POS)];

  // ==========================================================
  // Register space
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < REG_BYTES; i++) begin
        regs[i] <= REG_RST;
      end
    end else if (wr_en && acc_addr != DEV_ADDR_OFS) begin
      regs[acc_addr[AW-1:0]] <= fbuf[idx_reg]; // [RULE_12]
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      dev_addr_reg <= DEV_ADDR_RST; // [RULE_05]
    end else if (strap_take && !mode_s2_reg) begin
      dev_addr_reg[1:0] <= strap_s2_reg; // [RULE_05]
    end else if (wr_en && acc_addr == DEV_ADDR_OFS) begin
      dev_addr_reg <= fbuf[idx_reg]; // [RULE_06]
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (state_reg == ST_RD && k_reg != nbytes_reg) begin
      rbuf[6'(rlen_reg)] <= rd_byte; // [RULE_11] [RULE_14]
    end
  end

  // ==========================================================
  // Frame receive, execute and reply
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_reg <= ST_HUNT;
      fpos_reg <= '0;
      fcnt_reg <= '0;
      sum_reg <= '0;
      idx_reg <= '0;
      ptr_reg <= '0;
      nbytes_reg <= '0;
      k_reg <= '0;
      msb_reg <= 1'b0;
      fill_reg <= 1'b0;
      rlen_reg <= '0;
      rd_total_reg <= '0;
      wr_total_reg <= '0;
      head_reg <= ACK_BYTE;
      single_reg <= 1'b1;
      tlen_reg <= '0;
      tpos_reg <= '0;
      tsum_reg <= '0;
      tx_go_reg <= 1'b0;
      tx_byte_reg <= '0;
      MODE_DIR_OUT <= 1'b0;
    end else begin
      tx_go_reg <= 1'b0;
      case (state_reg)
        ST_HUNT: begin
          if (rx_beat.valid && rx_beat.data == FRAME_HDR) begin // [RULE_22] [RULE_23]
            sum_reg <= FRAME_HDR;
            rlen_reg <= '0;
            rd_total_reg <= '0;
            wr_total_reg <= '0;
            idx_reg <= FIRST_CMD_POS;
            state_reg <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (rx_beat.valid) begin
            sum_reg <= sum_reg + rx_beat.data; // [RULE_20]
            fcnt_reg <= rx_beat.data;
            fpos_reg <= FIRST_CMD_POS;
            state_reg <= (rx_beat.data < FRAME_MIN) ? ST_HUNT : ST_BODY; // [RULE_23]
          end
        end
        ST_BODY: begin
          if (rx_beat.valid) begin
            fpos_reg <= fpos_reg + 8'h01;
            if (fpos_reg != last) begin
              sum_reg <= sum_reg + rx_beat.data;
            end else if (sum_reg == rx_beat.data) begin
              state_reg <= quiet ? ST_HUNT : ST_EXEC; // [RULE_19]
            end else if (multi && !MODE_DIR_OUT) begin
              state_reg <= ST_HUNT; // [RULE_23]
            end else begin
              head_reg <= CHECKSUM_FAIL_REPLY_BYTE; // [RULE_20]
              single_reg <= 1'b1;
              state_reg <= ST_REPLY;
            end
          end
        end
        ST_EXEC: begin
          if (idx_reg == last) begin
            head_reg <= ACK_BYTE;
            single_reg <= (rlen_reg == 8'h00);
            state_reg <= ST_REPLY;
          end else if (overrun) begin
            head_reg <= NAK_BYTE;
            single_reg <= 1'b1;
            state_reg <= ST_REPLY;
          end else begin
            case (cmd)
              CMD_READ16, CMD_READ32, CMD_READN, CMD_PAGE_RD: begin // [RULE_07] [RULE_09]
                if (rd_over) begin
                  head_reg <= NAK_BYTE;
                  single_reg <= 1'b1;
                  state_reg <= ST_REPLY;
                end else begin
                  nbytes_reg <= nb;
                  k_reg <= '0;
                  msb_reg <= (cmd == CMD_READ16 || cmd == CMD_READ32); // [RULE_11]
                  fill_reg <= (cmd == CMD_PAGE_RD); // [RULE_10]
                  rd_total_reg <= rd_total_reg + nb; // [RULE_13]
                  idx_reg <= idx_reg + plen[7:0];
                  state_reg <= ST_RD;
                end
              end
              CMD_WRITE16, CMD_WRITE32, CMD_WRITEN: begin // [RULE_08] [RULE_09]
                if (wr_over) begin
                  head_reg <= NAK_BYTE;
                  single_reg <= 1'b1;
                  state_reg <= ST_REPLY;
                end else begin
                  nbytes_reg <= nb;
                  k_reg <= '0;
                  msb_reg <= (cmd != CMD_WRITEN);
                  fill_reg <= 1'b0;
                  wr_total_reg <= wr_total_reg + nb; // [RULE_15]
                  idx_reg <= idx_reg + plen[7:0] - nb;
                  state_reg <= ST_WR;
                end
              end
              CMD_SELECT, CMD_DESELECT, CMD_SAVE, CMD_ERASE: begin // [RULE_10]
                if (!addr_hit) begin
                  state_reg <= ST_HUNT;
                end else begin
                  if (multi && cmd == CMD_SELECT) begin
                    MODE_DIR_OUT <= 1'b1; // [RULE_16] [RULE_03]
                  end
                  if (multi && cmd == CMD_DESELECT) begin
                    MODE_DIR_OUT <= 1'b0; // [RULE_17]
                  end
                  idx_reg <= idx_reg + plen[7:0];
                end
              end
              CMD_SETPTR: begin
                if ({1'b0, p1, p2} >= REG_SPAN) begin
                  head_reg <= NAK_BYTE; // [RULE_18]
                  single_reg <= 1'b1;
                  state_reg <= ST_REPLY;
                end else begin
                  ptr_reg <= {p1, p2}; // [RULE_18]
                  idx_reg <= idx_reg + plen[7:0];
                end
              end
              CMD_PAGE_WR: begin
                idx_reg <= idx_reg + plen[7:0]; // [RULE_10]
              end
              default: begin
                head_reg <= NAK_BYTE;
                single_reg <= 1'b1;
                state_reg <= ST_REPLY;
              end
            endcase
          end
        end
        ST_RD: begin
          if (k_reg == nbytes_reg) begin
            state_reg <= ST_EXEC;
          end else begin
            rlen_reg <= rlen_reg + 8'h01;
            k_reg <= k_reg + 8'h01;
          end
        end
        ST_WR: begin
          if (k_reg == nbytes_reg) begin
            state_reg <= ST_EXEC;
          end else begin
            idx_reg <= idx_reg + 8'h01; // [RULE_12]
            k_reg <= k_reg + 8'h01;
          end
        end
        ST_REPLY: begin
          tlen_reg <= single_reg ? 8'h01 : rlen_reg + RESP_OVERHEAD; // [RULE_21]
          tpos_reg <= '0;
          tsum_reg <= '0;
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          if (!tx_busy && !tx_go_reg) begin
            tx_byte_reg <= tx_pick;
            tx_go_reg <= 1'b1;
            tsum_reg <= tsum_reg + tx_pick; // [RULE_21]
            tpos_reg <= tpos_reg + 8'h01;
            if (tpos_reg == tlen_reg - 8'h01) begin
              state_reg <= ST_HUNT;
            end
          end
        end
        default: state_reg <= ST_HUNT;
      endcase
    end
  end
endmodule

// ===== sim/uart_port_props.sv
`timescale 1ns/1ps
module uart_port_props #(
  parameter int unsigned BIT_CYCLES_P = 8
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic UART_RX,
  input wire logic UART_TX,
  input wire logic MODE_DIR_OUT,
  input wire logic MODE_DIR_OE_N
);
  // ====================
  // Helpers: age since reset, position in a sent byte
  logic [3:0] age_reg;
  logic [6:0] tx_cnt_reg;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) age_reg <= 4'h0;
    else if (age_reg != 4'hF) age_reg <= age_reg + 4'h1;
  end
  // Figures below hold for BIT_CYCLES_P = 8, eight cycles a bit
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) tx_cnt_reg <= 7'h00;
    else if (tx_cnt_reg == 7'h4F) tx_cnt_reg <= 7'h00;
    else if (tx_cnt_reg != 7'h00 || !UART_TX) tx_cnt_reg <= tx_cnt_reg + 7'h01;
  end
  // ====================
  // Properties
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence start_s; tx_cnt_reg == 7'h00 && !UART_TX; endsequence
  sequence low_s; !UART_TX [*8]; endsequence
  tx_start_a: assert property (start_s |-> low_s)
    else $error("start bit too short");
  tx_stop_a: assert property (tx_cnt_reg >= 7'h48 |-> UART_TX)
    else $error("stop bit not high");
  sel_ack_a: assert property ($rose(MODE_DIR_OUT) |-> ##[1:40] start_s)
    else $error("no reply after select");
  desel_ack_a: assert property ($fell(MODE_DIR_OUT) |-> ##[1:40] start_s)
    else $error("no reply after de-select");
  dir_multi_a: assert property (MODE_DIR_OUT |-> !MODE_DIR_OE_N)
    else $error("direction driven in single mode");
  oe_fixed_a: assert property (age_reg >= 4'h6 |-> $stable(MODE_DIR_OE_N))
    else $error("mode changed after strap capture");
  rx_done_a: assert property (start_s |-> UART_RX && $past(UART_RX, 4))
    else $error("reply started inside a received byte");
  tx_quiet_a: assert property (age_reg < 4'h8 |-> UART_TX)
    else $error("output right after reset");
endmodule
bind framed_uart_command_port uart_port_props #(.BIT_CYCLES_P(BIT_CYCLES_P)) u_props (
  .CORE_CLK, .SYS_RST, .UART_RX, .UART_TX, .MODE_DIR_OUT, .MODE_DIR_OE_N);

// ===== sim/host_uart_model.sv
`timescale 1ns/1ps
module host_uart_model #(
  parameter int unsigned BIT_CYC = 8
) (
  input wire logic clk,
  output logic line_out,
  input wire logic line_in
);
  initial line_out = 1'b1;
  // ====================
  // Ten bit times a byte, LSB first, no parity
  task automatic send(input logic [7:0] b);
    logic [9:0] sh;
    sh = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= sh[i];
      repeat (BIT_CYC) @(negedge clk);
    end
  endtask
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    ok = 1'b0;
    b = 8'h00;
    for (n = 0; n < 4000 && line_in; n++) @(negedge clk);
    if (!line_in) begin
      repeat (BIT_CYC / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(negedge clk);
        b[i] = line_in;
      end
      repeat (BIT_CYC) @(negedge clk);
      ok = line_in;
    end
  endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import uart_cmd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx, tx, d_out, d_oe_n, d_pin;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] fr[$];
  logic [7:0] rsp[$];
  logic [7:0] wd[4];
  logic [7:0] ptr;
  logic [7:0] adr;
  logic [1:0] strap;
  assign d_pin = d_oe_n ? 1'b0 : d_out;
  framed_uart_command_port #(.BIT_CYCLES_P(8)) i_framed_uart_command_port (
    .CORE_CLK(clk), .SYS_RST(rst), .UART_RX(rx), .UART_TX(tx),
    .MODE_DIR_IN(d_pin), .MODE_DIR_OUT(d_out), .MODE_DIR_OE_N(d_oe_n),
    .ADDRESS_STRAP_BIT0(strap[0]), .ADDRESS_STRAP_BIT1(strap[1]));
  host_uart_model #(.BIT_CYC(8)) host (.clk(clk), .line_out(rx), .line_in(tx));
  initial forever #20 clk = ~clk;
  // ====================
  // Checking
  function automatic logic [7:0] sum8(input logic [7:0] q[$]);
    sum8 = 8'h00;
    foreach (q[i]) sum8 += q[i];
  endfunction
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ====================
  // Frames
  task automatic send_frame(input logic [7:0] bump);
    fr.push_front(8'(fr.size() + 3));
    fr.push_front(FRAME_HDR);
    fr.push_back(sum8(fr) + bump);
    repeat (20) @(negedge clk);
    foreach (fr[i]) host.send(fr[i]);
    fr.delete();
  endtask
  task automatic expect_rsp();
    logic [7:0] b;
    logic ok;
    foreach (rsp[i]) begin
      host.recv(b, ok);
      chk("reply stop bit", 8'h01, {7'h00, ok});
      if (ok !== 1'b1) test_done();
      chk("reply byte", rsp[i], b);
    end
    rsp.delete();
  endtask
  task automatic data_rsp();
    rsp.push_front(8'(rsp.size() + 3));
    rsp.push_front(ACK_BYTE);
    rsp.push_back(sum8(rsp));
    expect_rsp();
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    test_done();
  end
  // ====================
  // Scenarios
  initial begin
    void'($urandom(32'hCDFB32DB));
    strap = 2'($urandom);
    adr = DEV_ADDR_RST | {6'h00, strap};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    chk("mode", 8'h00, {7'h00, d_oe_n});
    fr = {CMD_SELECT, adr};
    send_frame(8'h00);
    rsp = {ACK_BYTE};
    expect_rsp();
    chk("direction", 8'h01, {7'h00, d_out});
    fr = {CMD_SETPTR, 8'h00, 8'h26, CMD_READN, 8'h01};
    send_frame(8'h00);
    rsp = {adr};
    data_rsp();
    fr = {CMD_SAVE, adr, CMD_ERASE, adr, CMD_PAGE_RD, 8'h00, CMD_PAGE_WR};
    repeat (17) fr.push_back(8'($urandom));
    send_frame(8'h00);
    repeat (16) rsp.push_back(PAGE_FILL);
    data_rsp();
    for (int k = 0; k < 3; k++) begin
      ptr = (k == 0) ? 8'hFC : 8'($urandom_range(48, 240));
      foreach (wd[i]) wd[i] = 8'($urandom);
      fr = {CMD_SETPTR, 8'h00, ptr, CMD_WRITE16, ~wd[0], ~wd[1], CMD_READ16, CMD_WRITE32};
      fr = {fr, wd[0], wd[1], wd[2], wd[3], CMD_READ32, CMD_READN, 8'h04};
      send_frame(8'h00);
      rsp = {~wd[0], ~wd[1], wd[0], wd[1], wd[2], wd[3], wd[3], wd[2], wd[1], wd[0]};
      data_rsp();
      fr = {CMD_SETPTR, 8'h00, ptr, CMD_WRITE32, ~wd[0], ~wd[1], ~wd[2], ~wd[3]};
      send_frame(8'h01);
      rsp = {CHECKSUM_FAIL_REPLY_BYTE};
      expect_rsp();
      fr = {CMD_SETPTR, 8'h00, ptr, CMD_READN, 8'h04};
      send_frame(8'h00);
      rsp = {wd[3], wd[2], wd[1], wd[0]};
      data_rsp();
    end
    fr = {CMD_SETPTR, 8'h01, 8'h00};
    send_frame(8'h00);
    rsp = {NAK_BYTE};
    expect_rsp();
    fr = {CMD_SETPTR, 8'h00, 8'h30, CMD_READN, 8'h31};
    send_frame(8'h00);
    rsp = {NAK_BYTE};
    expect_rsp();
    fr = {CMD_SETPTR, 8'h00, 8'h26, CMD_WRITEN, 8'h01, 8'h60};
    send_frame(8'h00);
    rsp = {ACK_BYTE};
    expect_rsp();
    fr = {CMD_DESELECT, 8'h60};
    send_frame(8'h00);
    rsp = {ACK_BYTE};
    expect_rsp();
    chk("direction", 8'h00, {7'h00, d_out});
    test_done();
  end
endmodule
